// ---- design/rfirq_top.sv ----
module rfirq_top import rfirq_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic osc_ref_running,
  input wire logic osc_sena_running,
  input wire logic osc_senb_running,
  input wire logic measure_count_pulse,
  input wire logic timebase_inc_pulse,
  input wire logic timebase_dec_pulse,
  output logic [23:0] measurement_counter,
  output logic [23:0] time_base_counter,
  output logic osc_end_pulse,
  output logic rf_irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rfirq_state_t state_reg;
  rfirq_state_t state_next;
  logic [IDX_W-1:0] idx_reg;
  logic write_reg;
  logic [DATA_W-1:0] hrdata_reg;
  logic [NUM_EVT-1:0] rf_irq_enable_reg;
  logic [NUM_EVT-1:0] rf_irq_flags_reg;
  logic [NUM_EVT-1:0] set_vec;
  logic [NUM_EVT-1:0] clr_vec;
  logic [CNT_W-1:0] mc_reg;
  logic [CNT_W-1:0] tc_reg;
  logic addr_phase;
  logic wr_strobe;
  logic mc_ovf;
  logic tc_ovf;
  logic tc_zero;
  logic end_reg;

  // Register write hits one index in the data-phase wait cycle
  function automatic logic wr_hit(input logic strobe, input logic [IDX_W-1:0] idx,
                                  input logic [IDX_W-1:0] target);
    wr_hit = strobe && (idx == target);
  endfunction

  // Read mux; reserved and unmapped bits read as zero
  function automatic logic [DATA_W-1:0] read_mux(input logic [IDX_W-1:0] idx,
      input logic [NUM_EVT-1:0] en, input logic [NUM_EVT-1:0] fl,
      input logic [CNT_W-1:0] mc, input logic [CNT_W-1:0] tc);
    read_mux = '0;
    case (idx)
      IDX_MC_LO: read_mux[LO_W-1:0] = mc[LO_W-1:0];
      IDX_MC_HI: read_mux[CNT_W-LO_W-1:0] = mc[CNT_W-1:LO_W];
      IDX_TC_LO: read_mux[LO_W-1:0] = tc[LO_W-1:0];
      IDX_TC_HI: read_mux[CNT_W-LO_W-1:0] = tc[CNT_W-1:LO_W];
      IDX_IRQ_ENABLE: read_mux[NUM_EVT-1:0] = en;
      IDX_IRQ_FLAGS: read_mux[NUM_EVT-1:0] = fl;
      default: read_mux = '0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave: one wait state, then OKAY
  // ----------------------------------------------------------------

  // Address phase accepted
  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign wr_strobe = (state_reg == RF_ST_WAIT) && write_reg;

  // Next bus state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RF_ST_IDLE: if (addr_phase) state_next = RF_ST_WAIT;
      RF_ST_WAIT: state_next = RF_ST_DONE;
      RF_ST_DONE: state_next = addr_phase ? RF_ST_WAIT : RF_ST_IDLE;
      default: state_next = RF_ST_IDLE;
    endcase
  end

  // Bus state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= RF_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_reg <= '0;
      write_reg <= 1'b0;
    end else if (addr_phase && state_reg != RF_ST_WAIT) begin
      idx_reg <= haddr[IDX_LSB+IDX_W-1:IDX_LSB];
      write_reg <= hwrite;
    end
  end

  // Read data captured in the wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= '0;
    end else if (state_reg == RF_ST_WAIT && !write_reg) begin
      hrdata_reg <= read_mux(idx_reg, rf_irq_enable_reg, rf_irq_flags_reg, mc_reg, tc_reg);
    end
  end

  assign hreadyout = (state_reg != RF_ST_WAIT);
  assign hrdata = hrdata_reg;
  assign hresp = HRESP_OKAY;

  // ----------------------------------------------------------------
  // Interrupt enable register
  // ----------------------------------------------------------------

  // Software-written enables, upper bits dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rf_irq_enable_reg <= EVT_RESET;
    end else if (wr_hit(wr_strobe, idx_reg, IDX_IRQ_ENABLE)) begin
      rf_irq_enable_reg <= hwdata[NUM_EVT-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  assign mc_ovf = measure_count_pulse && (mc_reg == CNT_MAX);
  assign tc_ovf = timebase_inc_pulse && (tc_reg == CNT_MAX);
  assign tc_zero = timebase_dec_pulse && (tc_reg == CNT_ONE);

  // Measurement counter: write wins over counting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mc_reg <= CNT_RESET;
    end else if (wr_hit(wr_strobe, idx_reg, IDX_MC_LO)) begin
      mc_reg[LO_W-1:0] <= hwdata[LO_W-1:0];
    end else if (wr_hit(wr_strobe, idx_reg, IDX_MC_HI)) begin
      mc_reg[CNT_W-1:LO_W] <= hwdata[CNT_W-LO_W-1:0];
    end else if (measure_count_pulse) begin
      mc_reg <= mc_reg + CNT_ONE;
    end
  end

  // Time base counter counts up for reference, down for sensors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tc_reg <= CNT_RESET;
    end else if (wr_hit(wr_strobe, idx_reg, IDX_TC_LO)) begin
      tc_reg[LO_W-1:0] <= hwdata[LO_W-1:0];
    end else if (wr_hit(wr_strobe, idx_reg, IDX_TC_HI)) begin
      tc_reg[CNT_W-1:LO_W] <= hwdata[CNT_W-LO_W-1:0];
    end else if (timebase_inc_pulse) begin
      tc_reg <= tc_reg + CNT_ONE;
    end else if (timebase_dec_pulse && tc_reg != CNT_RESET) begin
      tc_reg <= tc_reg - CNT_ONE;
    end
  end

  assign measurement_counter = mc_reg;
  assign time_base_counter = tc_reg;

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------

  // Event causes
  always_comb begin
    set_vec = '0;
    set_vec[BIT_TB_OVF] = tc_ovf && osc_ref_running;
    set_vec[BIT_MEAS_OVF] = mc_ovf && (osc_sena_running || osc_senb_running);
    set_vec[BIT_SENB_DONE] = tc_zero && osc_senb_running;
    set_vec[BIT_SENA_DONE] = tc_zero && osc_sena_running;
    set_vec[BIT_REF_DONE] = mc_ovf && osc_ref_running;
  end

  // Write-one-to-clear mask
  assign clr_vec = wr_hit(wr_strobe, idx_reg, IDX_IRQ_FLAGS) ? hwdata[NUM_EVT-1:0] : '0;

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rf_irq_flags_reg <= EVT_RESET;
    end else begin
      rf_irq_flags_reg <= (rf_irq_flags_reg & ~clr_vec) | set_vec;
    end
  end

  // Oscillation end notice to the core
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      end_reg <= 1'b0;
    end else begin
      end_reg <= |set_vec;
    end
  end

  assign osc_end_pulse = end_reg;

  // Level interrupt to the controller
  assign rf_irq = |(rf_irq_flags_reg & rf_irq_enable_reg);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Enabled flags drive the interrupt line
  property p_tb_gate;
    rf_irq_flags_reg[BIT_TB_OVF] && rf_irq_enable_reg[BIT_TB_OVF] |-> rf_irq;
  endproperty
  a_tb_gate: assert property (p_tb_gate) else $error("timebase irq missing");

  property p_meas_gate;
    rf_irq_flags_reg[BIT_MEAS_OVF] && rf_irq_enable_reg[BIT_MEAS_OVF] |-> rf_irq;
  endproperty
  a_meas_gate: assert property (p_meas_gate) else $error("measure irq missing");

  property p_senb_gate;
    rf_irq_flags_reg[BIT_SENB_DONE] && rf_irq_enable_reg[BIT_SENB_DONE] |-> rf_irq;
  endproperty
  a_senb_gate: assert property (p_senb_gate) else $error("sensor b irq missing");

  property p_sena_gate;
    rf_irq_flags_reg[BIT_SENA_DONE] && rf_irq_enable_reg[BIT_SENA_DONE] |-> rf_irq;
  endproperty
  a_sena_gate: assert property (p_sena_gate) else $error("sensor a irq missing");

  property p_ref_gate;
    rf_irq_flags_reg[BIT_REF_DONE] && rf_irq_enable_reg[BIT_REF_DONE] |-> rf_irq;
  endproperty
  a_ref_gate: assert property (p_ref_gate) else $error("reference irq missing");

  // Event causes set their flags
  property p_tb_ovf;
    timebase_inc_pulse && tc_reg == CNT_MAX && osc_ref_running && !wr_strobe
      |=> rf_irq_flags_reg[BIT_TB_OVF] && tc_reg == CNT_RESET;
  endproperty
  a_tb_ovf: assert property (p_tb_ovf) else $error("timebase overflow flag not set");

  property p_meas_ovf;
    measure_count_pulse && mc_reg == CNT_MAX && (osc_sena_running || osc_senb_running)
      |=> rf_irq_flags_reg[BIT_MEAS_OVF] && osc_end_pulse;
  endproperty
  a_meas_ovf: assert property (p_meas_ovf) else $error("measure overflow flag not set");

  property p_senb_done;
    timebase_dec_pulse && !timebase_inc_pulse && tc_reg == CNT_ONE
      && osc_senb_running && !wr_strobe
      |=> rf_irq_flags_reg[BIT_SENB_DONE] && tc_reg == CNT_RESET;
  endproperty
  a_senb_done: assert property (p_senb_done) else $error("sensor b done not set");

  property p_sena_done;
    timebase_dec_pulse && tc_reg == CNT_ONE && osc_sena_running
      |=> rf_irq_flags_reg[BIT_SENA_DONE];
  endproperty
  a_sena_done: assert property (p_sena_done) else $error("sensor a done not set");

  property p_ref_done;
    measure_count_pulse && mc_reg == CNT_MAX && osc_ref_running
      |=> rf_irq_flags_reg[BIT_REF_DONE];
  endproperty
  a_ref_done: assert property (p_ref_done) else $error("reference done not set");

  // Register writes and bus timing
  property p_w1c;
    wr_hit(wr_strobe, idx_reg, IDX_IRQ_FLAGS) && hwdata[BIT_REF_DONE]
      && !set_vec[BIT_REF_DONE] |=> !rf_irq_flags_reg[BIT_REF_DONE];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

  property p_sticky;
    rf_irq_flags_reg[BIT_SENA_DONE] && !clr_vec[BIT_SENA_DONE]
      |=> rf_irq_flags_reg[BIT_SENA_DONE];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear");

  property p_mc_write;
    wr_hit(wr_strobe, idx_reg, IDX_MC_LO)
      |=> mc_reg[LO_W-1:0] == $past(hwdata[LO_W-1:0]) && hreadyout;
  endproperty
  a_mc_write: assert property (p_mc_write) else $error("counter write lost");

  property p_irq_hold;
    rf_irq && !(|clr_vec) && !wr_hit(wr_strobe, idx_reg, IDX_IRQ_ENABLE)
      |=> rf_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped early");

  property p_no_cause;
    !osc_ref_running && !osc_sena_running && !osc_senb_running
      && rf_irq_flags_reg == EVT_RESET |=> rf_irq_flags_reg == EVT_RESET;
  endproperty
  a_no_cause: assert property (p_no_cause) else $error("flag set while idle");

  property p_en_write;
    wr_hit(wr_strobe, idx_reg, IDX_IRQ_ENABLE)
      |=> rf_irq_enable_reg == $past(hwdata[NUM_EVT-1:0]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write lost");

  property p_tc_hi;
    wr_hit(wr_strobe, idx_reg, IDX_TC_HI)
      |=> tc_reg[CNT_W-1:LO_W] == $past(hwdata[CNT_W-LO_W-1:0])
      && tc_reg[LO_W-1:0] == $past(tc_reg[LO_W-1:0]);
  endproperty
  a_tc_hi: assert property (p_tc_hi) else $error("time base high write wrong");

  property p_end_pulse;
    (|set_vec) |=> osc_end_pulse;
  endproperty
  a_end_pulse: assert property (p_end_pulse) else $error("end notice missing");

  property p_reserved;
    state_reg == RF_ST_WAIT && !write_reg
      && (idx_reg == IDX_IRQ_FLAGS || idx_reg == IDX_IRQ_ENABLE)
      |=> hrdata[DATA_W-1:NUM_EVT] == '0 && hreadyout;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_wait_one;
    state_reg == RF_ST_WAIT |-> !hreadyout ##1 hreadyout;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait state length wrong");

  c_ref_done: cover property (set_vec[BIT_REF_DONE] ##1 rf_irq);
  c_clear: cover property (rf_irq ##[1:20] !rf_irq);
  c_read_flags: cover property (state_reg == RF_ST_WAIT && idx_reg == IDX_IRQ_FLAGS);
  c_set_clear: cover property (|(set_vec & clr_vec));
  c_tb_ovf: cover property (set_vec[BIT_TB_OVF] ##1 rf_irq);

endmodule // rfirq_top

// ---- common/rfirq_pkg.sv ----
// Summary of operation
// - Timebase overflow enable gates its interrupt, resets 0
// - Measure overflow enable gates its interrupt, resets 0
// - Sensor B done enable gates its interrupt
// - Sensor A done enable gates its interrupt
// - Reference done enable gates its interrupt
// - Timebase overflow during reference sets flag
// - Measure overflow during sensor oscillation sets flag
// - Timebase reaching zero during sensor B oscillation sets sensor B flag
// - Timebase reaching zero during sensor A oscillation sets sensor A flag
// - Measure overflow during reference sets done flag
// - Flags sticky; write one clears, zero ignored
// - Two 24-bit counters, software readable, writable
package rfirq_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int IDX_W = 15;
  localparam logic [IDX_W-1:0] IDX_MC_LO = 15'h53a4;
  localparam logic [IDX_W-1:0] IDX_MC_HI = 15'h53a6;
  localparam logic [IDX_W-1:0] IDX_TC_LO = 15'h53a8;
  localparam logic [IDX_W-1:0] IDX_TC_HI = 15'h53aa;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 15'h53ac;
  localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS = 15'h53ae;
  localparam int IDX_LSB = 2;

  // ----------------------------------------------------------------
  // Field layout of enable and flag registers
  // ----------------------------------------------------------------
  localparam int NUM_EVT = 5;
  localparam int BIT_REF_DONE = 0;
  localparam int BIT_SENA_DONE = 1;
  localparam int BIT_SENB_DONE = 2;
  localparam int BIT_MEAS_OVF = 3;
  localparam int BIT_TB_OVF = 4;
  localparam logic [NUM_EVT-1:0] EVT_RESET = 5'h00;

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  localparam int CNT_W = 24;
  localparam int LO_W = 16;
  localparam logic [CNT_W-1:0] CNT_RESET = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_MAX = 24'hffffff;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

  // ----------------------------------------------------------------
  // Bus
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'h0;

  typedef enum logic [1:0] {RF_ST_IDLE, RF_ST_WAIT, RF_ST_DONE} rfirq_state_t;

endpackage

// ---- test/rfirq_core_model.sv ----
module rfirq_core_model (
  input wire logic hclk,
  output logic osc_ref_running,
  output logic osc_sena_running,
  output logic osc_senb_running,
  output logic measure_count_pulse,
  output logic timebase_inc_pulse,
  output logic timebase_dec_pulse
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Converter core: idle at time zero
  // ----------------------------------------------------------------
  initial begin
    {osc_senb_running, osc_sena_running, osc_ref_running} = 3'h0;
    {timebase_dec_pulse, timebase_inc_pulse, measure_count_pulse} = 3'h0;
  end

  // Runs one oscillation with a single burst of counter pulses; gap sets a slow start
  task automatic fire(input logic [2:0] run, input logic [2:0] pls, input int gap);
    @(posedge hclk);
    {osc_senb_running, osc_sena_running, osc_ref_running} <= run;
    repeat (gap) @(posedge hclk);
    @(posedge hclk);
    {timebase_dec_pulse, timebase_inc_pulse, measure_count_pulse} <= pls;
    @(posedge hclk);
    {timebase_dec_pulse, timebase_inc_pulse, measure_count_pulse} <= 3'h0;
    @(posedge hclk);
    {osc_senb_running, osc_sena_running, osc_ref_running} <= 3'h0;
  endtask
endmodule // rfirq_core_model

// ---- test/rfirq_bench.sv ----
module rfirq_bench;
  import rfirq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, osc_end_pulse, rf_irq;
  logic [31:0] hrdata;
  logic osc_ref_running, osc_sena_running, osc_senb_running;
  logic measure_count_pulse, timebase_inc_pulse, timebase_dec_pulse;
  logic [23:0] mc_out, tc_out;
  int num_errors = 0;
  int n_tests = 0;
  int n_end = 0;

  // ----------------------------------------------------------------
  // Clock, design and core model
  // ----------------------------------------------------------------
  always #2.5 hclk = ~hclk;

  // Counts end notices from the design
  always @(posedge hclk) begin
    if (osc_end_pulse === 1'b1) begin
      n_end <= n_end + 1;
    end
  end

  rfirq_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .osc_ref_running(osc_ref_running),
    .osc_sena_running(osc_sena_running), .osc_senb_running(osc_senb_running),
    .measure_count_pulse(measure_count_pulse), .timebase_inc_pulse(timebase_inc_pulse),
    .timebase_dec_pulse(timebase_dec_pulse), .measurement_counter(mc_out),
    .time_base_counter(tc_out), .osc_end_pulse(osc_end_pulse), .rf_irq(rf_irq));

  rfirq_core_model u_core (.hclk(hclk), .osc_ref_running(osc_ref_running),
    .osc_sena_running(osc_sena_running), .osc_senb_running(osc_senb_running),
    .measure_count_pulse(measure_count_pulse), .timebase_inc_pulse(timebase_inc_pulse),
    .timebase_dec_pulse(timebase_dec_pulse));

  // ----------------------------------------------------------------
  // Bus access and comparison tasks
  // ----------------------------------------------------------------
  // One single-word transfer; ready is sampled at each rising edge
  task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    haddr <= {15'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, idx, d, dummy);
  endtask

  task automatic chk_word(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, idx, 32'h0, got);
    n_tests++;
    if (got !== exp || hresp !== HRESP_OKAY) begin
      num_errors++;
      $display("[ERR] %0t read %h got %h expected %h resp %b",
               $time, idx, got, exp, hresp);
    end
  endtask

  task automatic chk_out(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t output %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_irq(input logic exp);
    @(posedge hclk);
    n_tests++;
    if (rf_irq !== exp) begin
      num_errors++;
      $display("[ERR] %0t irq line %b expected %b", $time, rf_irq, exp);
    end
  endtask

  // Loads a counter low half first, runs one oscillation, then checks the flags
  task automatic ev(input logic [IDX_W-1:0] lo, input logic [23:0] v, input logic [2:0] run,
                    input logic [2:0] pls, input logic [31:0] expf);
    wr(IDX_IRQ_FLAGS, 32'h1f);
    wr(lo, {16'h0, v[15:0]});
    wr(lo + 15'h2, {24'h0, v[23:16]});
    u_core.fire(run, pls, 2);
    chk_word(IDX_IRQ_FLAGS, expf);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_word(IDX_IRQ_ENABLE, 32'h0);
    chk_word(IDX_IRQ_FLAGS, 32'h0);
    chk_word(IDX_MC_LO, 32'h0);
    chk_word(IDX_TC_HI, 32'h0);
    chk_irq(1'b0);
    $display("test reset done");
    wr(IDX_IRQ_ENABLE, 32'hffffffff);
    chk_word(IDX_IRQ_ENABLE, 32'h1f);
    wr(15'h0100, 32'hffffffff);
    chk_word(15'h0100, 32'h0);
    wr(IDX_TC_LO, 32'h1234abcd);
    wr(IDX_TC_HI, 32'h5a5a5a5a);
    chk_word(IDX_TC_LO, 32'habcd);
    chk_word(IDX_TC_HI, 32'h5a);
    chk_out(tc_out, 24'h5aabcd);
    $display("test registers done");
    // Flags are cleared before each oscillation starts
    ev(IDX_MC_LO, 24'hffffff, 3'h0, 3'h1, 32'h00);
    chk_word(IDX_MC_LO, 32'h0);
    chk_out(mc_out, 24'h000000);
    ev(IDX_MC_LO, 24'hffffff, 3'h1, 3'h1, 32'h01);
    chk_irq(1'b1);
    ev(IDX_TC_LO, 24'hffffff, 3'h1, 3'h2, 32'h10);
    ev(IDX_TC_LO, 24'h000001, 3'h2, 3'h4, 32'h02);
    ev(IDX_TC_LO, 24'h000001, 3'h4, 3'h4, 32'h04);
    ev(IDX_MC_LO, 24'hffffff, 3'h2, 3'h1, 32'h08);
    ev(IDX_MC_LO, 24'hffffff, 3'h4, 3'h1, 32'h08);
    chk_out(n_end[23:0], 24'h000006);
    $display("test events done");
    // Sets all five flags, then walks the enables one at a time
    wr(IDX_MC_LO, 32'hffff);
    wr(IDX_MC_HI, 32'hff);
    u_core.fire(3'h1, 3'h1, 0);
    wr(IDX_TC_LO, 32'h1);
    wr(IDX_TC_HI, 32'h0);
    u_core.fire(3'h2, 3'h4, 0);
    wr(IDX_TC_LO, 32'h1);
    u_core.fire(3'h4, 3'h4, 0);
    wr(IDX_MC_LO, 32'hffff);
    wr(IDX_MC_HI, 32'hff);
    u_core.fire(3'h2, 3'h1, 0);
    wr(IDX_TC_LO, 32'hffff);
    wr(IDX_TC_HI, 32'hff);
    u_core.fire(3'h1, 3'h2, 0);
    chk_word(IDX_IRQ_FLAGS, 32'h1f);
    chk_out(n_end[23:0], 24'h00000b);
    for (int i = 0; i < NUM_EVT; i++) begin
      wr(IDX_IRQ_ENABLE, 32'h1 << i);
      chk_irq(1'b1);
      wr(IDX_IRQ_ENABLE, 32'hffffffe0);
      chk_irq(1'b0);
    end
    $display("test enables done");
    wr(IDX_IRQ_ENABLE, 32'h1f);
    wr(IDX_IRQ_FLAGS, 32'hffffffe0);
    chk_word(IDX_IRQ_FLAGS, 32'h1f);
    for (int i = 0; i < NUM_EVT; i++) begin
      wr(IDX_IRQ_FLAGS, 32'h1 << i);
      chk_word(IDX_IRQ_FLAGS, (32'h1f << (i + 1)) & 32'h1f);
    end
    chk_irq(1'b0);
    $display("test clearing done");
    summarize();
  end

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    summarize();
  end
endmodule // rfirq_bench
